//--- design/dis_defines.svh
// Constants for the input sync control block
// Assumes inclusion by the package and the design file
`ifndef DIS_DEFINES_SVH
`define DIS_DEFINES_SVH
`define DIS_DATA_W      16
`define DIS_MIDSCALE    16'h8000
`define DIS_ADDR_W      4
`define DIS_OFS_CTRL    4'h0
`define DIS_OFS_STATUS  4'h1
`define DIS_OFS_IRQ_ST  4'h2
`define DIS_OFS_IRQ_EN  4'h3
`define DIS_OFS_IRQ_CLR 4'h4
`define DIS_OFS_PHASE   4'h5
`define DIS_CTRL_SYNC   0
`define DIS_CTRL_FLAG   1
`define DIS_CTRL_ILV    2
`define DIS_CTRL_PLL    3
`define DIS_EV_TXRISE   0
`define DIS_EV_STROBE   1
`define DIS_EV_LOCK     2
`define DIS_EV_W        3
`define DIS_DIV_W       4
`endif

//--- design/dis_pkg.sv
// Types for the input sync control block
// Assumes the defines header is on the include path
`include "dis_defines.svh"
package dis_pkg;
	typedef logic [`DIS_DATA_W-1:0] dis_sample_t;
	typedef logic [31:0]            dis_word_t;
	typedef logic [`DIS_ADDR_W-1:0] dis_addr_t;
	typedef enum logic {DIS_CH_A, DIS_CH_B} dis_chan_t;
endpackage

//--- design/dis_core.sv
// Input sync control: de-interleave, midscale, strobe, lock and registers
// Assumes all inputs synchronous to clock_i; reset_n and sleep are pins
//
// Contract
// - A high phase strobe clears the oscillator phase accumulator always.
// - With strobe sync select 0 the strobe leaves the divided clock alone.
// - With select 1 in external clock mode a strobe rise sets divider phase.
// - In PLL mode the lock output is high exactly while the PLL is locked.
// - In external clock mode the lock output carries the input-rate clock.
// - With flag select 1 in interleaved mode the flag picks the channel.
// - A sample presented with the flag high goes to channel B.
// - Unless the flag picks the channel, each transmit enable rise realigns the A/B pairing.
// - After that rise the first sample is A, then B, alternating.
// - While transmit enable is low both outputs hold midscale.
// - While chip reset is low all logic is held in reset.
// - Sleep high powers down at once, without a clock edge.
// - Samples are captured on the data clock.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "dis_defines.svh"
module dis_core #(
	parameter int DIV_W = `DIS_DIV_W
) (
	input  wire logic             clock_i,
	input  wire logic             srst_i,
	input  wire logic             chip_reset_n_i,
	input  wire logic             sleep_i,
	input  wire logic             transmit_enable_in_i,
	input  wire logic             channel_flag_i,
	input  wire logic             phase_strobe_i,
	input  wire logic             pll_locked_i,
	input  wire dis_pkg::dis_sample_t channel_a_data_i,
	input  wire dis_pkg::dis_sample_t channel_b_data_i,
	input  wire dis_pkg::dis_addr_t   addr_i,
	input  wire dis_pkg::dis_word_t   wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic                  power_down_o,
	output dis_pkg::dis_word_t    rdata_o,
	output logic                  irq_o,
	output dis_pkg::dis_sample_t  dac_a_o,
	output dis_pkg::dis_sample_t  dac_b_o,
	output logic                  acc_clear_o,
	output logic [DIV_W-1:0]      div_phase_o,
	output logic                  lock_status_out_o
);
	import dis_pkg::*;

	logic                 rst;
	logic [3:0]           ctrl_reg;
	logic [2:0]           s1_reg;
	logic [2:0]           s2_reg;
	logic                 tx_d_reg;
	logic                 st_d_reg;
	logic                 lk_d_reg;
	logic                 armed_reg;
	dis_chan_t            chan_reg;
	dis_chan_t            chan_next;
	dis_sample_t          dac_a_reg;
	dis_sample_t          dac_b_reg;
	dis_sample_t          hold_a_reg;
	logic                 acc_reg;
	logic [DIV_W-1:0]     div_reg;
	logic                 rate_reg;
	logic                 lock_reg;
	logic [`DIS_EV_W-1:0] ev_st_reg;
	logic [`DIS_EV_W-1:0] ev_en_reg;
	logic                 irq_reg;
	dis_word_t            rdata_reg;

	// Chip reset folds into the core reset
	assign rst = srst_i | ~chip_reset_n_i;

	// Sleep passes straight through to power-down
	assign power_down_o = sleep_i;

	// Two-stage synchronisers, stage one read only by stage two
	always_ff @(posedge clock_i) begin
		if (rst) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
		end else begin
			s1_reg <= {channel_flag_i, phase_strobe_i, transmit_enable_in_i};
			s2_reg <= s1_reg;
		end
	end

	wire tx_s     = s2_reg[0];
	wire strobe_s = s2_reg[1];
	wire flag_s   = s2_reg[2];
	wire tx_rise  = tx_s & ~tx_d_reg;
	wire st_rise  = strobe_s & ~st_d_reg;
	wire sync_sel = ctrl_reg[`DIS_CTRL_SYNC];
	wire flag_sel = ctrl_reg[`DIS_CTRL_FLAG];
	wire ilv_mode = ctrl_reg[`DIS_CTRL_ILV];
	wire pll_mode = ctrl_reg[`DIS_CTRL_PLL];
	wire use_flag = ilv_mode & flag_sel;

	// Flag high steers the sample to channel B
	wire dis_chan_t cur_chan = use_flag ? (flag_s ? DIS_CH_B : DIS_CH_A)
		: (tx_rise ? DIS_CH_A : chan_reg);

	// Rise restarts at A, then alternate once armed
	assign chan_next = (tx_rise | ~armed_reg) ? DIS_CH_B :
		((chan_reg == DIS_CH_A) ? DIS_CH_B : DIS_CH_A);

	wire ev_lock = lock_reg ^ lk_d_reg;
	wire [`DIS_EV_W-1:0] ev_now = {ev_lock & pll_mode, st_rise, tx_rise};
	wire wr_ctrl = wr_i & (addr_i == `DIS_OFS_CTRL);
	wire wr_en   = wr_i & (addr_i == `DIS_OFS_IRQ_EN);
	wire wr_clr  = wr_i & (addr_i == `DIS_OFS_IRQ_CLR);
	wire [`DIS_EV_W-1:0] clr_bits = wr_clr ? wdata_i[`DIS_EV_W-1:0]
		: {`DIS_EV_W{1'b0}};

	dis_word_t rd_mux;
	assign rd_mux =
		(addr_i == `DIS_OFS_CTRL)   ? {28'h0, ctrl_reg} :
		(addr_i == `DIS_OFS_STATUS) ? {29'h0, lock_reg, tx_s, chan_reg} :
		(addr_i == `DIS_OFS_IRQ_ST) ? {29'h0, ev_st_reg} :
		(addr_i == `DIS_OFS_IRQ_EN) ? {29'h0, ev_en_reg} :
		(addr_i == `DIS_OFS_PHASE)  ? {{(32-DIV_W){1'b0}}, div_reg} :
		32'h0;

	always_ff @(posedge clock_i) begin
		if (rst) begin
			tx_d_reg  <= 1'b0;
			st_d_reg  <= 1'b0;
			lk_d_reg  <= 1'b0;
			armed_reg <= 1'b0;
			chan_reg  <= DIS_CH_A;
			ctrl_reg  <= 4'h0;
		end else begin
			tx_d_reg <= tx_s;
			st_d_reg <= strobe_s;
			lk_d_reg <= lock_reg;
			if (tx_rise)
				armed_reg <= 1'b1;
			if (tx_s & armed_reg & ~use_flag)
				chan_reg <= chan_next;
			else if (tx_rise)
				chan_reg <= DIS_CH_B;
			if (wr_ctrl)
				ctrl_reg <= wdata_i[3:0];
		end
	end

	// Samples captured on the data clock
	// Midscale while transmit enable is low
	always_ff @(posedge clock_i) begin
		if (rst | ~tx_s) begin
			dac_a_reg  <= `DIS_MIDSCALE;
			dac_b_reg  <= `DIS_MIDSCALE;
			hold_a_reg <= `DIS_MIDSCALE;
		end else if (!ilv_mode) begin
			dac_a_reg <= channel_a_data_i;
			dac_b_reg <= channel_b_data_i;
		end else if (cur_chan == DIS_CH_A) begin
			hold_a_reg <= channel_a_data_i;
		end else begin
			dac_a_reg <= hold_a_reg;
			dac_b_reg <= channel_a_data_i;
		end
	end

	// Accumulator clear follows the strobe whatever the select
	// Divider phase set only with select 1 in external mode
	always_ff @(posedge clock_i) begin
		if (rst) begin
			acc_reg  <= 1'b0;
			div_reg  <= '0;
			rate_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			acc_reg <= strobe_s;
			if (st_rise & sync_sel & ~pll_mode)
				div_reg <= '0;
			else
				div_reg <= div_reg + 1'b1;
			rate_reg <= ~rate_reg;
			// Lock output source by clock mode
			lock_reg <= pll_mode ? pll_locked_i : ~rate_reg;
		end
	end

	// Sticky events: set wins over clear
	always_ff @(posedge clock_i) begin
		if (rst) begin
			ev_st_reg <= '0;
			ev_en_reg <= '0;
			irq_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			ev_st_reg <= (ev_st_reg & ~clr_bits) | ev_now;
			if (wr_en)
				ev_en_reg <= wdata_i[`DIS_EV_W-1:0];
			irq_reg   <= |(ev_st_reg & ev_en_reg);
			rdata_reg <= rd_i ? rd_mux : 32'h0;
		end
	end

	assign dac_a_o           = dac_a_reg;
	assign dac_b_o           = dac_b_reg;
	assign acc_clear_o       = acc_reg;
	assign div_phase_o       = div_reg;
	assign lock_status_out_o = lock_reg;
	assign irq_o             = irq_reg;
	assign rdata_o           = rdata_reg;

	mid_scale_a: assert property (
		@(posedge clock_i) disable iff (rst)
		!tx_s |=> dac_a_reg == `DIS_MIDSCALE
			&& dac_b_reg == `DIS_MIDSCALE)
		else $error("output not midscale while disabled");
	acc_clear_a: assert property (
		@(posedge clock_i) disable iff (rst)
		strobe_s |=> acc_reg)
		else $error("accumulator not cleared");
	div_free_a: assert property (
		@(posedge clock_i) disable iff (rst)
		!sync_sel |=> div_reg == $past(div_reg) + 1'b1)
		else $error("divider disturbed with select 0");
	div_set_a: assert property (
		@(posedge clock_i) disable iff (rst)
		st_rise && sync_sel && !pll_mode |=> div_reg == '0)
		else $error("divider phase not set");
	lock_pll_a: assert property (
		@(posedge clock_i) disable iff (rst)
		pll_mode |=> lock_reg == $past(pll_locked_i))
		else $error("lock output wrong");
	lock_ext_a: assert property (
		@(posedge clock_i) disable iff (rst)
		!pll_mode ##1 !pll_mode |=> lock_reg != $past(lock_reg))
		else $error("rate clock not toggling");
	chan_start_a: assert property (
		@(posedge clock_i) disable iff (rst)
		tx_rise && !use_flag |=> chan_reg == DIS_CH_B)
		else $error("first sample not A");
	chan_hold_a: assert property (
		@(posedge clock_i) disable iff (rst)
		!armed_reg |-> chan_reg == DIS_CH_A)
		else $error("alternation before first enable");
	sync_two_a: assert property (
		@(posedge clock_i) disable iff (rst)
		$rose(phase_strobe_i) ##1 phase_strobe_i |=> strobe_s)
		else $error("synchroniser delay wrong");
	realign_a: assert property (
		@(posedge clock_i) disable iff (rst)
		tx_rise && ilv_mode && !use_flag
			|=> hold_a_reg == $past(channel_a_data_i))
		else $error("sample after enable rise not taken as A");
	flag_a_a: assert property (
		@(posedge clock_i) disable iff (rst)
		use_flag && tx_s && !flag_s
			|=> hold_a_reg == $past(channel_a_data_i))
		else $error("flag low sample not held as A");
	flag_b_a: assert property (
		@(posedge clock_i) disable iff (rst)
		use_flag && tx_s && flag_s
			|=> dac_b_reg == $past(channel_a_data_i)
			&& dac_a_reg == $past(hold_a_reg))
		else $error("flag high sample not steered to B");
	par_pass_a: assert property (
		@(posedge clock_i) disable iff (rst)
		tx_s && !ilv_mode
			|=> dac_a_reg == $past(channel_a_data_i)
			&& dac_b_reg == $past(channel_b_data_i))
		else $error("parallel samples not captured");
	reset_hold_a: assert property (
		@(posedge clock_i)
		rst |=> ctrl_reg == 4'h0 && ev_st_reg == '0 && !irq_reg
			&& dac_a_reg == `DIS_MIDSCALE)
		else $error("state not cleared by reset");
	// Event set wins over clear
	sticky_set_a: assert property (
		@(posedge clock_i) disable iff (rst)
		(|ev_now) |=> (ev_st_reg & $past(ev_now)) == $past(ev_now))
		else $error("event lost against clear");
	// Interrupt follows enabled status
	irq_level_a: assert property (
		@(posedge clock_i) disable iff (rst)
		(|(ev_st_reg & ev_en_reg)) |=> irq_reg)
		else $error("interrupt not raised");

	// Main scenarios
	ilv_run_c: cover property (@(posedge clock_i) tx_rise && ilv_mode);
	flag_b_c:  cover property (@(posedge clock_i) use_flag && flag_s && tx_s);
	div_set_c: cover property (@(posedge clock_i) st_rise && sync_sel);
	lock_ev_c: cover property (@(posedge clock_i) pll_mode && ev_lock);
	par_run_c: cover property (@(posedge clock_i) tx_rise && !ilv_mode);
endmodule // dis_core

//--- bench/dis_host.sv
// Host model: transmit enable, channel flag and sample buses
// Assumes the device clock; buses are pulled low while idle
`timescale 1ns/100ps
module dis_host (
	input  wire logic        clock_i,
	input  wire logic        run_i,
	input  wire logic        odd_i,
	input  wire logic [11:0] rand_i,
	output logic             tx_o = 1'b0,
	output logic             flag_o = 1'b0,
	output logic [15:0]      a_o = 16'h0000,
	output logic [15:0]      b_o = 16'h0000
);
	logic [7:0] cnt_reg = 8'h00;
	always @(posedge clock_i) begin
		// odd_i opens a flag run on a B sample
		cnt_reg <= run_i ? cnt_reg + 8'h01 : {7'h00, odd_i};
		tx_o <= run_i;
		flag_o <= run_i & cnt_reg[0];
		a_o <= run_i ? {cnt_reg[0] ? 4'hB : 4'hA, rand_i} : 16'h0000;
		b_o <= run_i ? {4'hC, rand_i} : 16'h0000;
	end
endmodule // dis_host

//--- bench/tb_top.sv
// Testbench: streams, registers, strobe, lock, sleep, reset
// Assumes the design files and the host model are compiled first
`timescale 1ns/100ps
`include "dis_defines.svh"
module tb_top;
	import dis_pkg::*;
	logic        clock_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        rstn = 1'b1;
	logic        sleep_i = 1'b0;
	logic        pll = 1'b0;
	logic        strb = 1'b0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        run = 1'b0;
	logic        odd = 1'b0;
	logic        tx, flag, irq, acc, lock, pd, l;
	dis_addr_t   addr_i = '0;
	dis_word_t   wdata_i = '0;
	dis_word_t   rdata;
	dis_sample_t a, b, da, db;
	logic [3:0]  div;
	logic [3:0]  dv;
	logic [3:0]  modes [3] = '{4'h0, 4'h4, 4'h6};
	logic [11:0] rnd = 12'h000;
	logic [31:0] seed = 32'hCF23205A;
	int          fail_count = 0;
	int          checked = 0;
	always #2.5 clock_i = ~clock_i;
	always @(posedge clock_i) rnd <= 12'($random(seed));
	dis_host dis_host_inst (.clock_i(clock_i), .run_i(run), .odd_i(odd),
		.rand_i(rnd), .tx_o(tx), .flag_o(flag), .a_o(a), .b_o(b));
	dis_core dis_core_inst (.clock_i(clock_i), .srst_i(srst_i),
		.chip_reset_n_i(rstn), .sleep_i(sleep_i),
		.transmit_enable_in_i(tx), .channel_flag_i(flag),
		.phase_strobe_i(strb), .pll_locked_i(pll),
		.channel_a_data_i(a), .channel_b_data_i(b), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .power_down_o(pd),
		.rdata_o(rdata), .irq_o(irq), .dac_a_o(da), .dac_b_o(db),
		.acc_clear_o(acc), .div_phase_o(div), .lock_status_out_o(lock));
	task automatic close_out();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_w(input dis_word_t g, input dis_word_t e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t word %h not %h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t bit %b not %b", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input dis_addr_t ad, input dis_word_t d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= ad;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input dis_addr_t ad, input dis_word_t e);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= ad;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk_w(rdata, e);
	endtask
	function automatic dis_word_t exp_b(input logic [3:0] m);
		return m[2] ? 32'hB : 32'hC;
	endfunction
	initial begin
		#50000;
		fail_count++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clock_i);
		srst_i <= 1'b0;
		rd(`DIS_OFS_CTRL, 32'h0);
		rd(4'hF, 32'h0);
		wr(`DIS_OFS_IRQ_EN, 32'h1);
		rd(`DIS_OFS_IRQ_EN, 32'h1);
		foreach (modes[i]) begin
			odd <= modes[i][1];
			wr(`DIS_OFS_CTRL, {28'h0, modes[i]});
			run <= 1'b1;
			cyc(12);
			repeat (8) begin
				if (modes[i][2]) chk_w(da[15:12], 32'hA);
				chk_w(db[15:12], exp_b(modes[i]));
				cyc(1);
			end
			run <= 1'b0;
			cyc(4);
			chk_w(da, `DIS_MIDSCALE);
			chk_w(db, `DIS_MIDSCALE);
		end
		chk_b(irq, 1'b1);
		rd(`DIS_OFS_IRQ_ST, 32'h1);
		wr(`DIS_OFS_IRQ_CLR, 32'h1);
		cyc(2);
		chk_b(irq, 1'b0);
		wr(`DIS_OFS_CTRL, 32'h1);
		@(posedge clock_i);
		strb <= 1'b1;
		cyc(4);
		chk_b(acc, 1'b1);
		chk_w(div, 32'h1);
		@(posedge clock_i);
		strb <= 1'b0;
		cyc(4);
		chk_b(acc, 1'b0);
		wr(`DIS_OFS_CTRL, 32'h8);
		repeat (4) begin
			@(posedge clock_i);
			pll <= rnd[0];
			cyc(3);
			chk_b(lock, pll);
		end
		wr(`DIS_OFS_CTRL, 32'h0);
		cyc(2);
		l = lock;
		cyc(1);
		chk_b(lock, ~l);
		@(posedge clock_i);
		strb <= 1'b1;
		#1 dv = div;
		cyc(4);
		dv = dv + 4'h4;
		chk_b(acc, 1'b1);
		chk_w(div, dv);
		@(posedge clock_i);
		strb <= 1'b0;
		@(posedge clock_i);
		sleep_i <= 1'b1;
		#1 chk_b(pd, 1'b1);
		@(posedge clock_i);
		sleep_i <= 1'b0;
		#1 chk_b(pd, 1'b0);
		odd <= 1'b0;
		wr(`DIS_OFS_CTRL, 32'h4);
		run <= 1'b1;
		cyc(10);
		@(posedge clock_i);
		rstn <= 1'b0;
		cyc(2);
		chk_w(da, `DIS_MIDSCALE);
		@(posedge clock_i);
		rstn <= 1'b1;
		run <= 1'b0;
		rd(`DIS_OFS_CTRL, 32'h0);
		close_out();
	end
endmodule // tb_top
